// ===== hw/vpa_defines.vh
// constants for the virtual port alias and event output block
`ifndef VPA_DEFINES_VH
`define VPA_DEFINES_VH

`define VPA_AW 9
`define VPA_DW 8
`define VPA_NPORT 16
`define VPA_NPIN 128

// configuration register offsets
`define VPA_A_MULTI_PIN_CONFIG_MASK 9'h000
`define VPA_A_VMAP_A 9'h002
`define VPA_A_VMAP_B 9'h003
`define VPA_A_CLKEV 9'h004
`define VPA_A_EBI 9'h005
`define VPA_A_EVENT_OUT_CONTROL 9'h006
`define VPA_A_IRQ_STAT 9'h008
`define VPA_A_IRQ_MASK 9'h009

// virtual slot window: base + 4 * slot, then dir/out/in/flags
`define VPA_VWIN_TAG 5'h01
// physical port window: bit 8 set, port in [7:4], register in [3:0]
`define VPA_PWIN_BIT 8

// physical port register codes
`define VPA_R_DIR 4'h0
`define VPA_R_DIRSET 4'h1
`define VPA_R_DIRCLR 4'h2
`define VPA_R_DIRTGL 4'h3
`define VPA_R_OUT 4'h4
`define VPA_R_OUTSET 4'h5
`define VPA_R_OUTCLR 4'h6
`define VPA_R_OUTTGL 4'h7
`define VPA_R_IN 4'h8
`define VPA_R_MASK0 4'ha
`define VPA_R_MASK1 4'hb
`define VPA_R_FLAGS 4'hc
`define VPA_R_SENSE 4'hf

// clock_event_pin_route fields
`define VPA_CE_PIN4 7
`define VPA_CE_RTC 6
`define VPA_CE_EVPORT_HI 5
`define VPA_CE_EVPORT_LO 4
`define VPA_CE_CSEL_HI 3
`define VPA_CE_CSEL_LO 2
`define VPA_CE_CPORT_HI 1
`define VPA_CE_CPORT_LO 0
`define VPA_ROUTE_OFF 2'h0
`define VPA_PIN_ALT 3'h4
`define VPA_PIN_DEF 3'h7
`define VPA_ROUTE_BASE 7'h08

// writable bits of the ext bus route, event control and port flag registers
`define VPA_EBI_WMASK 8'h0f
`define VPA_EVSEL_WMASK 8'h07
`define VPA_FLAG_WMASK 8'h03

// input sense modes
`define VPA_SNS_BOTH 2'h0
`define VPA_SNS_RISE 2'h1
`define VPA_SNS_FALL 2'h2
`define VPA_SNS_LOW 2'h3

`define VPA_RST8 8'h00

`endif

// ===== hw/vpa_sync2.v
// two flip-flop synchroniser for the pin inputs
`timescale 1ns/1ps
`default_nettype none
module vpa_sync2 #(
   parameter W = 128
) (
   input wire clk_sys_in,
   input wire rst_b_in,
   input wire [W-1:0] async_in,
   output wire [W-1:0] sync_out
);
   reg [W-1:0] meta_q;
   reg [W-1:0] sync_q;

   always @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         meta_q <= {W{1'b0}};
         sync_q <= {W{1'b0}};
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end

   assign sync_out = sync_q;
endmodule // vpa_sync2
`default_nettype wire

// ===== hw/vpa_pin_sense.v
// per-port input sense matcher feeding the two port interrupts
`timescale 1ns/1ps
`default_nettype none
`include "vpa_defines.vh"
module vpa_pin_sense (
   input wire clk_sys_in,
   input wire rst_b_in,
   input wire [7:0] pins_in,
   input wire [1:0] sense_in,
   input wire [7:0] src0_in,
   input wire [7:0] src1_in,
   output wire hit0_out,
   output wire hit1_out
);
   reg [7:0] prev_q;
   reg [7:0] match;

   always @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         prev_q <= `VPA_RST8;
      end else begin
         prev_q <= pins_in;
      end
   end

   always @* begin
      case (sense_in)
         `VPA_SNS_BOTH: match = pins_in ^ prev_q;
         `VPA_SNS_RISE: match = pins_in & ~prev_q;
         `VPA_SNS_FALL: match = ~pins_in & prev_q;
         `VPA_SNS_LOW: match = ~pins_in;
         default: match = `VPA_RST8;
      endcase
   end

   assign hit0_out = |(match & src0_in);
   assign hit1_out = |(match & src1_in);
endmodule // vpa_pin_sense
`default_nettype wire

// ===== hw/vpa_top.v
// virtual port aliases, physical port registers and event output routing
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "vpa_defines.vh"
module vpa_top (
   input wire clk_sys_in,
   input wire rst_b_in,
   input wire [8:0] reg_addr_in,
   input wire [7:0] reg_wdata_in,
   input wire reg_wr_in,
   input wire reg_rd_in,
   output wire [7:0] reg_rdata_out,
   input wire [127:0] pin_in,
   output wire [127:0] pin_out_out,
   output wire [127:0] pin_oe_b_out,
   input wire [7:0] ev_chan_in,
   output wire [127:0] clk_pin_en_out,
   output wire [1:0] clk_src_sel_out,
   output wire rtc_out_en_out,
   output wire [3:0] ebi_route_out,
   output wire [7:0] pin_cfg_mask_out,
   output wire irq_out
);
   // decode result: valid, port, register code
   function [8:0] vpa_decode;
      input [8:0] a;
      input [15:0] vmaps;
      reg [1:0] slot;
      begin
         slot = a[3:2];
         vpa_decode = 9'h000;
         if (a[`VPA_PWIN_BIT]) begin
            vpa_decode = {1'b1, a[7:4], a[3:0]};
         end else if (a[8:4] == `VPA_VWIN_TAG) begin
            vpa_decode = {1'b1, vmaps[slot*4 +: 4], a[1:0], 2'b00};
         end
      end
   endfunction

   reg [7:0] mpc_mask_q;
   reg [7:0] vmap_a_q;
   reg [7:0] vmap_b_q;
   reg [7:0] clkev_q;
   reg [7:0] ebi_q;
   reg [7:0] event_out_control_q;
   reg [1:0] irq_stat_q;
   reg [1:0] irq_mask_q;
   reg [7:0] rdata_q;
   reg [7:0] rd_val;
   reg [127:0] pad_out_q;
   reg [127:0] pad_oe_b_q;
   reg [127:0] clk_mask_q;
   reg [127:0] ev_mask_d;
   reg [127:0] clk_mask_d;

   wire [8:0] dec;
   wire dv;
   wire [3:0] dport;
   wire [3:0] dreg;
   wire cfg_wr;
   wire [127:0] pins_s;
   wire [127:0] dir_w;
   wire [127:0] out_w;
   wire [31:0] flags_w;
   wire [127:0] mask0_w;
   wire [127:0] mask1_w;
   wire [31:0] sense_w;
   wire [15:0] set0_w;
   wire [15:0] set1_w;
   wire [15:0] new0_w;
   wire [15:0] new1_w;
   wire [1:0] ev_port;
   wire [1:0] clk_port;
   wire [2:0] route_pin;
   wire [6:0] ev_idx;
   wire [6:0] clk_idx;
   wire ev_bit;

   // alias resolves to the physical port
   assign dec = vpa_decode(reg_addr_in, {vmap_b_q, vmap_a_q});
   assign dv = dec[8];
   assign dport = dec[7:4];
   assign dreg = dec[3:0];
   assign cfg_wr = reg_wr_in && !reg_addr_in[`VPA_PWIN_BIT];

   vpa_sync2 #(
      .W(`VPA_NPIN)
   ) u_sync (
      .clk_sys_in(clk_sys_in),
      .rst_b_in(rst_b_in),
      .async_in(pin_in),
      .sync_out(pins_s)
   );

   genvar g;
   generate
      for (g = 0; g < `VPA_NPORT; g = g + 1) begin : g_port
         localparam [3:0] PIDX = g;
         reg [7:0] dir_q;
         reg [7:0] out_q;
         reg [1:0] flags_q;
         reg [7:0] m0_q;
         reg [7:0] m1_q;
         reg [1:0] sense_q;
         wire hit;
         wire h0;
         wire h1;
         wire [1:0] clr;
         wire [1:0] setv;

         assign hit = reg_wr_in && dv && (dport == PIDX);
         assign clr = (hit && dreg == `VPA_R_FLAGS) ? reg_wdata_in[1:0] : 2'b00;
         assign setv = {h1, h0};

         vpa_pin_sense u_sense (
            .clk_sys_in(clk_sys_in),
            .rst_b_in(rst_b_in),
            .pins_in(pins_s[g*8 +: 8]),
            .sense_in(sense_q),
            .src0_in(m0_q),
            .src1_in(m1_q),
            .hit0_out(h0),
            .hit1_out(h1)
         );

         always @(posedge clk_sys_in or negedge rst_b_in) begin
            if (!rst_b_in) begin
               dir_q <= `VPA_RST8;
               out_q <= `VPA_RST8;
               flags_q <= 2'b00;
               m0_q <= `VPA_RST8;
               m1_q <= `VPA_RST8;
               sense_q <= `VPA_SNS_BOTH;
            end else begin
               // set wins over a same-cycle clear
               flags_q <= (flags_q & ~clr) | setv;
               if (hit) begin
                  // alias and direct write share one path
                  case (dreg)
                     `VPA_R_DIR: dir_q <= reg_wdata_in;
                     `VPA_R_DIRSET: dir_q <= dir_q | reg_wdata_in;
                     `VPA_R_DIRCLR: dir_q <= dir_q & ~reg_wdata_in;
                     `VPA_R_DIRTGL: dir_q <= dir_q ^ reg_wdata_in;
                     `VPA_R_OUT: out_q <= reg_wdata_in;
                     `VPA_R_OUTSET: out_q <= out_q | reg_wdata_in;
                     `VPA_R_OUTCLR: out_q <= out_q & ~reg_wdata_in;
                     `VPA_R_OUTTGL: out_q <= out_q ^ reg_wdata_in;
                     `VPA_R_MASK0: m0_q <= reg_wdata_in;
                     `VPA_R_MASK1: m1_q <= reg_wdata_in;
                     `VPA_R_SENSE: sense_q <= reg_wdata_in[1:0];
                     default: dir_q <= dir_q;
                  endcase
               end
            end
         end

         assign dir_w[g*8 +: 8] = dir_q;
         assign out_w[g*8 +: 8] = out_q;
         assign flags_w[g*2 +: 2] = flags_q;
         assign mask0_w[g*8 +: 8] = m0_q;
         assign mask1_w[g*8 +: 8] = m1_q;
         assign sense_w[g*2 +: 2] = {1'b0, 1'b0} | sense_q;
         assign set0_w[g] = h0;
         assign set1_w[g] = h1;
         assign new0_w[g] = h0 && !flags_q[0];
         assign new1_w[g] = h1 && !flags_q[1];
      end
   endgenerate

   // configuration registers and interrupt status
   always @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         mpc_mask_q <= `VPA_RST8;
         vmap_a_q <= `VPA_RST8;
         vmap_b_q <= `VPA_RST8;
         clkev_q <= `VPA_RST8;
         ebi_q <= `VPA_RST8;
         event_out_control_q <= `VPA_RST8;
         irq_stat_q <= 2'b00;
         irq_mask_q <= 2'b00;
      end else begin
         irq_stat_q <= (irq_stat_q & ~((cfg_wr && reg_addr_in == `VPA_A_IRQ_STAT) ?
            reg_wdata_in[1:0] : 2'b00)) | {|new1_w, |new0_w};
         if (cfg_wr) begin
            case (reg_addr_in)
               `VPA_A_MULTI_PIN_CONFIG_MASK: mpc_mask_q <= reg_wdata_in;
               `VPA_A_VMAP_A: vmap_a_q <= reg_wdata_in;
               `VPA_A_VMAP_B: vmap_b_q <= reg_wdata_in;
               `VPA_A_CLKEV: clkev_q <= reg_wdata_in;
               `VPA_A_EBI: ebi_q <= reg_wdata_in & `VPA_EBI_WMASK;
               `VPA_A_EVENT_OUT_CONTROL: event_out_control_q <= reg_wdata_in & `VPA_EVSEL_WMASK;
               `VPA_A_IRQ_MASK: irq_mask_q <= reg_wdata_in[1:0];
               default: mpc_mask_q <= mpc_mask_q;
            endcase
         end
      end
   end

   // read mux
   always @* begin
      rd_val = `VPA_RST8;
      if (dv) begin
         case (dreg)
            `VPA_R_DIR: rd_val = dir_w[dport*8 +: 8];
            `VPA_R_OUT: rd_val = out_w[dport*8 +: 8];
            `VPA_R_IN: rd_val = pins_s[dport*8 +: 8];
            `VPA_R_MASK0: rd_val = mask0_w[dport*8 +: 8];
            `VPA_R_MASK1: rd_val = mask1_w[dport*8 +: 8];
            `VPA_R_FLAGS: rd_val = {6'h00, flags_w[dport*2 +: 2]};
            `VPA_R_SENSE: rd_val = {6'h00, sense_w[dport*2 +: 2]};
            default: rd_val = `VPA_RST8;
         endcase
      end else begin
         case (reg_addr_in)
            `VPA_A_MULTI_PIN_CONFIG_MASK: rd_val = mpc_mask_q;
            `VPA_A_VMAP_A: rd_val = vmap_a_q;
            `VPA_A_VMAP_B: rd_val = vmap_b_q;
            `VPA_A_CLKEV: rd_val = clkev_q;
            `VPA_A_EBI: rd_val = ebi_q;
            `VPA_A_EVENT_OUT_CONTROL: rd_val = event_out_control_q;
            `VPA_A_IRQ_STAT: rd_val = {6'h00, irq_stat_q};
            `VPA_A_IRQ_MASK: rd_val = {6'h00, irq_mask_q};
            default: rd_val = `VPA_RST8;
         endcase
      end
   end

   always @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rdata_q <= `VPA_RST8;
      end else if (reg_rd_in) begin
         rdata_q <= rd_val;
      end else begin
         rdata_q <= `VPA_RST8;
      end
   end

   // event and clock pin routing; port code is route code plus one
   assign ev_port = clkev_q[`VPA_CE_EVPORT_HI:`VPA_CE_EVPORT_LO];
   assign clk_port = clkev_q[`VPA_CE_CPORT_HI:`VPA_CE_CPORT_LO];
   assign route_pin = clkev_q[`VPA_CE_PIN4] ? `VPA_PIN_ALT : `VPA_PIN_DEF;
   assign ev_idx = {2'b00, ev_port, route_pin} + `VPA_ROUTE_BASE;
   assign clk_idx = {2'b00, clk_port, route_pin} + `VPA_ROUTE_BASE;
   assign ev_bit = ev_chan_in[event_out_control_q[2:0]];

   always @* begin
      ev_mask_d = {`VPA_NPIN{1'b0}};
      clk_mask_d = {`VPA_NPIN{1'b0}};
      if (clk_port != `VPA_ROUTE_OFF) begin
         clk_mask_d[clk_idx] = 1'b1;
      end
      if (ev_port != `VPA_ROUTE_OFF &&
         !(clk_port != `VPA_ROUTE_OFF && clk_idx == ev_idx)) begin
         ev_mask_d[ev_idx] = 1'b1;
      end
   end

   always @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         pad_out_q <= {`VPA_NPIN{1'b0}};
         pad_oe_b_q <= {`VPA_NPIN{1'b1}};
         clk_mask_q <= {`VPA_NPIN{1'b0}};
      end else begin
         // port output value drives the pad, except the routed event pin, which takes ev_bit
         pad_out_q <= (out_w & ~ev_mask_d) | (ev_mask_d & {`VPA_NPIN{ev_bit}});
         pad_oe_b_q <= ~dir_w;
         clk_mask_q <= clk_mask_d;
      end
   end

   assign reg_rdata_out = rdata_q;
   assign pin_out_out = pad_out_q;
   assign pin_oe_b_out = pad_oe_b_q;
   assign clk_pin_en_out = clk_mask_q;
   assign clk_src_sel_out = clkev_q[`VPA_CE_CSEL_HI:`VPA_CE_CSEL_LO];
   assign rtc_out_en_out = clkev_q[`VPA_CE_RTC];
   assign ebi_route_out = ebi_q[3:0];
   assign pin_cfg_mask_out = mpc_mask_q;
   assign irq_out = |(irq_stat_q & irq_mask_q);
endmodule // vpa_top
`default_nettype wire

// ===== verif/vpa_top_checker.sv
// port checker for the virtual port alias block
`timescale 1ns/1ps
`default_nettype none
module vpa_top_checker (
   input wire logic clk_sys_in,
   input wire logic rst_b_in,
   input wire logic [8:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [7:0] reg_rdata_out,
   input wire logic [127:0] pin_in,
   input wire logic [127:0] pin_out_out,
   input wire logic [127:0] pin_oe_b_out,
   input wire logic [7:0] ev_chan_in,
   input wire logic [127:0] clk_pin_en_out,
   input wire logic irq_out
);
   logic [7:0] vm_q, ce_q, ev_q, mk_q;
   // shadow of map, route and mask registers
   always @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         vm_q <= 8'h00;
         ce_q <= 8'h00;
         ev_q <= 8'h00;
         mk_q <= 8'h00;
      end else if (reg_wr_in) begin
         if (reg_addr_in == 9'h002) vm_q <= reg_wdata_in;
         if (reg_addr_in == 9'h004) ce_q <= reg_wdata_in;
         if (reg_addr_in == 9'h006) ev_q <= reg_wdata_in & 8'h07;
         if (reg_addr_in == 9'h009) mk_q <= reg_wdata_in;
      end
   end
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!rst_b_in);
   sequence s_wrrd(wa, ra);
      reg_wr_in && reg_addr_in == wa ##1 reg_rd_in && reg_addr_in == ra;
   endsequence
   sequence s_dir1;
      reg_wr_in && (reg_addr_in == 9'h110 || reg_addr_in == 9'h010 && vm_q[3:0] == 4'h1)
         ##1 !reg_wr_in;
   endsequence
   a_out_direct:
      assert property (s_wrrd(9'h114, 9'h114) |=> reg_rdata_out == $past(reg_wdata_in, 2))
         else $error("out readback wrong");
   a_dir_alias:
      assert property (s_wrrd(9'h010, {1'b1, vm_q[3:0], 4'h0})
         |=> reg_rdata_out == $past(reg_wdata_in, 2)) else $error("dir alias wrong");
   a_map_alias:
      assert property (s_wrrd(9'h011, {1'b1, vm_q[3:0], 4'h4})
         |=> reg_rdata_out == $past(reg_wdata_in, 2)) else $error("out alias wrong");
   a_flag_clear:
      assert property (s_wrrd(9'h013, {1'b1, vm_q[3:0], 4'hc})
         |=> (reg_rdata_out & $past(reg_wdata_in, 2)) == 8'h00) else $error("flag not cleared");
   a_dir_pad:
      assert property (s_dir1 |=> pin_oe_b_out[15:8] == ~$past(reg_wdata_in, 2))
         else $error("pad enable wrong");
   a_in_read:
      assert property (reg_rd_in && reg_addr_in == 9'h118 && $stable(pin_in[15:8])
         && $past(pin_in[15:8], 2) == pin_in[15:8] |=> reg_rdata_out == $past(pin_in[15:8]))
         else $error("input read wrong");
   a_ev_route:
      assert property ($past(ce_q) == 8'h10 |-> pin_out_out[23] == $past(ev_chan_in[ev_q[2:0]]))
         else $error("event pin wrong");
   a_clk_wins:
      assert property ($past(ce_q) == 8'h11 |-> clk_pin_en_out[23] && $onehot(clk_pin_en_out))
         else $error("clock pin not chosen");
   a_irq_masked:
      assert property (mk_q == 8'h00 |-> !irq_out) else $error("masked irq raised");
endmodule // vpa_top_checker
bind vpa_top vpa_top_checker u_chk (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
   .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
   .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .pin_in(pin_in),
   .pin_out_out(pin_out_out), .pin_oe_b_out(pin_oe_b_out), .ev_chan_in(ev_chan_in),
   .clk_pin_en_out(clk_pin_en_out), .irq_out(irq_out));
`default_nettype wire

// ===== verif/vpa_core_bfm.sv
// processor core model driving the register port
`timescale 1ns/1ps
`default_nettype none
module vpa_core_bfm (
   input wire logic clk_sys_in,
   input wire logic [7:0] reg_rdata_in,
   output logic [8:0] reg_addr_out = 9'h000,
   output logic [7:0] reg_wdata_out = 8'h00,
   output logic reg_wr_out = 1'b0,
   output logic reg_rd_out = 1'b0
);
   // write strobe stays up between back-to-back wr_reg calls; rd_reg drops both strobes
   task automatic wr_reg(input logic [8:0] a, input logic [7:0] d);
      reg_addr_out <= a;
      if (a[8:4] == 5'h01 && a[1:0] == 2'h3 || a[8] && a[3:0] == 4'hc)
         reg_wdata_out <= d & 8'h03;
      else
         reg_wdata_out <= d;
      reg_wr_out <= 1'b1;
      reg_rd_out <= 1'b0;
      @(posedge clk_sys_in);
   endtask
   task automatic idle();
      reg_wr_out <= 1'b0;
      reg_rd_out <= 1'b0;
      @(posedge clk_sys_in);
   endtask
   task automatic rd_reg(input logic [8:0] a, output logic [7:0] d);
      reg_addr_out <= a;
      reg_wr_out <= 1'b0;
      reg_rd_out <= 1'b1;
      @(posedge clk_sys_in);
      idle();
      d = reg_rdata_in;
   endtask
endmodule // vpa_core_bfm
`default_nettype wire

// ===== verif/vpa_top_tb.sv
// self-checking bench for the virtual port alias block
`timescale 1ns/1ps
`default_nettype none
module vpa_top_tb;
   logic clk_sys_in, rst_b_in, reg_wr_in, reg_rd_in, irq_out;
   logic [8:0] reg_addr_in;
   logic [7:0] reg_wdata_in, reg_rdata_out, ev_chan_in, rd_v;
   logic [127:0] pin_in, pin_out_out, pin_oe_b_out, clk_pin_en_out;
   logic [1:0] clk_src_sel_out;
   logic rtc_out_en_out;
   logic [3:0] ebi_route_out;
   logic [7:0] pin_cfg_mask_out;
   int fail_count, cmp_count;
   // write addr, data, read addr, expected
   logic [33:0] rows [17] = '{{9'h002, 8'h21, 9'h002, 8'h21}, {9'h003, 8'hf3, 9'h003, 8'hf3},
      {9'h010, 8'ha5, 9'h110, 8'ha5}, {9'h011, 8'h5a, 9'h114, 8'h5a},
      {9'h01d, 8'h3c, 9'h1f4, 8'h3c}, {9'h018, 8'h0f, 9'h130, 8'h0f},
      {9'h006, 8'hff, 9'h006, 8'h07}, {9'h005, 8'hff, 9'h005, 8'h0f},
      {9'h001, 8'hff, 9'h001, 8'h00}, {9'h114, 8'h77, 9'h114, 8'h77},
      {9'h000, 8'h3c, 9'h011, 8'h77}, {9'h121, 8'h81, 9'h120, 8'h81},
      {9'h122, 8'h01, 9'h120, 8'h80}, {9'h123, 8'h03, 9'h120, 8'h83},
      {9'h125, 8'hf0, 9'h124, 8'hf0}, {9'h126, 8'h30, 9'h124, 8'hc0},
      {9'h127, 8'h81, 9'h124, 8'h41}};
   vpa_core_bfm cpu (.clk_sys_in(clk_sys_in), .reg_rdata_in(reg_rdata_out),
      .reg_addr_out(reg_addr_in), .reg_wdata_out(reg_wdata_in), .reg_wr_out(reg_wr_in),
      .reg_rd_out(reg_rd_in));
   vpa_top dut (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .reg_addr_in(reg_addr_in),
      .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
      .reg_rdata_out(reg_rdata_out), .pin_in(pin_in), .pin_out_out(pin_out_out),
      .pin_oe_b_out(pin_oe_b_out), .ev_chan_in(ev_chan_in), .clk_pin_en_out(clk_pin_en_out),
      .clk_src_sel_out(clk_src_sel_out), .rtc_out_en_out(rtc_out_en_out),
      .ebi_route_out(ebi_route_out), .pin_cfg_mask_out(pin_cfg_mask_out),
      .irq_out(irq_out));
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
      cmp_count++;
      if (s !== e) begin
         fail_count++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic rdc(input string n, input logic [8:0] a, input logic [7:0] e);
      cpu.rd_reg(a, rd_v);
      chk(n, e, rd_v);
   endtask
   task automatic stop_test();
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      clk_sys_in = 1'b0;
      forever #20 clk_sys_in = ~clk_sys_in;
   end
   // about 180 cycles needed
   initial begin
      #200000;
      fail_count++;
      stop_test();
   end
   initial begin
      rst_b_in = 1'b0;
      pin_in = '0;
      ev_chan_in = 8'h00;
      repeat (2) @(posedge clk_sys_in);
      rst_b_in <= 1'b1;
      @(posedge clk_sys_in);
      chk("oe_b", 8'hff, pin_oe_b_out[15:8]);
      chk("irq", 8'h00, {7'h0, irq_out});
      for (int i = 0; i < 4; i++) rdc("reset", 9'h002 + 9'(i), 8'h00);
      foreach (rows[i]) begin
         cpu.wr_reg(rows[i][33:25], rows[i][24:17]);
         rdc("row", rows[i][16:8], rows[i][7:0]);
      end
      chk("oe_b1", ~8'ha5, pin_oe_b_out[15:8]);
      chk("out1", 8'h77, pin_out_out[15:8]);
      chk("out15", 8'h3c, pin_out_out[127:120]);
      chk("mpc_mask", 8'h3c, pin_cfg_mask_out);
      chk("ebi_route", 8'h0f, {4'h0, ebi_route_out});
      pin_in[15:8] <= 8'h94;
      repeat (4) cpu.idle();
      rdc("in_alias", 9'h012, 8'h94);
      rdc("in_port", 9'h118, 8'h94);
      cpu.idle();
      chk("rd_idle", 8'h00, reg_rdata_out);
      cpu.wr_reg(9'h11f, 8'h01);
      cpu.wr_reg(9'h11a, 8'h01);
      cpu.wr_reg(9'h11b, 8'h02);
      cpu.wr_reg(9'h009, 8'h03);
      pin_in[9:8] <= 2'b11;
      repeat (5) cpu.idle();
      rdc("flags", 9'h013, 8'h03);
      chk("irq_set", 8'h01, {7'h0, irq_out});
      cpu.wr_reg(9'h013, 8'hfe);
      rdc("flag_keep", 9'h11c, 8'h01);
      cpu.wr_reg(9'h009, 8'h00);
      cpu.idle();
      chk("irq_mask", 8'h00, {7'h0, irq_out});
      cpu.wr_reg(9'h009, 8'h03);
      cpu.idle();
      chk("irq_unmask", 8'h01, {7'h0, irq_out});
      cpu.wr_reg(9'h013, 8'h03);
      rdc("flag_clr", 9'h11c, 8'h00);
      cpu.wr_reg(9'h008, 8'h03);
      cpu.idle();
      chk("irq_clr", 8'h00, {7'h0, irq_out});
      // falling edge, low level and both edges sense modes
      cpu.wr_reg(9'h11f, 8'h02);
      pin_in[9:8] <= 2'b00;
      repeat (5) cpu.idle();
      rdc("fall", 9'h11c, 8'h03);
      cpu.wr_reg(9'h11f, 8'h03);
      cpu.wr_reg(9'h11c, 8'h03);
      rdc("low_set_wins", 9'h11c, 8'h03);
      cpu.wr_reg(9'h11f, 8'h00);
      cpu.wr_reg(9'h11c, 8'h03);
      pin_in[8] <= 1'b1;
      repeat (5) cpu.idle();
      rdc("both", 9'h11c, 8'h01);
      cpu.wr_reg(9'h120, 8'h80);
      cpu.wr_reg(9'h004, 8'h10);
      for (int c = 0; c < 8; c++) begin
         cpu.wr_reg(9'h006, 8'(c));
         ev_chan_in <= 8'h01 << c;
         repeat (3) cpu.idle();
         chk("ev_high", 8'h01, {7'h0, pin_out_out[23]});
         ev_chan_in <= ~(8'h01 << c);
         repeat (3) cpu.idle();
         chk("ev_low", 8'h00, {7'h0, pin_out_out[23]});
      end
      chk("ev_oe_b", 8'h00, {7'h0, pin_oe_b_out[23]});
      cpu.wr_reg(9'h004, 8'h11);
      repeat (2) cpu.idle();
      chk("clk_pin", 8'h01, {7'h0, clk_pin_en_out[23]});
      cpu.wr_reg(9'h004, 8'h4d);
      cpu.idle();
      chk("clk_sel", 8'h03, {6'h0, clk_src_sel_out});
      chk("rtc_en", 8'h01, {7'h0, rtc_out_en_out});
      // reset again in mid-run
      rst_b_in <= 1'b0;
      cpu.idle();
      chk("rst_oe_b", 8'h01, {7'h0, pin_oe_b_out[23]});
      chk("rst_clk", 8'h00, {7'h0, |clk_pin_en_out});
      chk("rst_irq", 8'h00, {7'h0, irq_out});
      rst_b_in <= 1'b1;
      rdc("rst_route", 9'h004, 8'h00);
      stop_test();
   end
endmodule // vpa_top_tb
`default_nettype wire
